// ### common/cell_params.svh
`ifndef CELL_PARAMS_SVH
`define CELL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CELL_OFS_CTRL 8'h00
`define CELL_OFS_LUT 8'h04
`define CELL_OFS_STATUS 8'h08
`define CELL_OFS_INPUTS 8'h0c
`define CELL_OFS_TOGGLES 8'h10
`define CELL_OFS_W 8

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_FOURTH_BIT 2
`define CTRL_OUTREG_BIT 3
`define CTRL_CASCADE_BIT 4
`define CTRL_ALOAD_BIT 5
`define CTRL_W 6
`define CTRL_RST 6'h00

// ----------------------------------------
// table register fields
// ----------------------------------------
`define LUT_W 16
`define LUT_RST 16'h0000
`define TABLE_A_LSB 0
`define TABLE_A_MSB 7
`define TABLE_B_LSB 8
`define TABLE_B_MSB 15

// ----------------------------------------
// data input roles in counter modes, and fourth table input in normal mode
// ----------------------------------------
`define DIN_LOAD_DATA 0
`define DIN_LOAD_EN 1
`define DIN_COUNT_EN 2
`define DIN_FOURTH 3

// ----------------------------------------
// misc widths and reset values
// ----------------------------------------
`define TOGGLE_W 16
`define TOGGLE_RST 16'h0000
`define TOGGLE_STEP 16'h0001

// ----------------------------------------
// status and input readback fields
// ----------------------------------------
`define STATUS_W 4
`define INPUTS_CELL_MSB 5
`define INPUTS_PIN_LSB 6
`define INPUTS_PIN_MSB 9
`define Q_RST 1'b0

`endif

// ### common/cell_pkg.sv
package cell_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ARITH,
        MODE_UPDOWN,
        MODE_CLEARABLE
    } cell_mode_t;

    typedef struct packed {
        logic aload_en;
        logic cascade_en;
        logic out_reg_sel;
        logic fourth_sel;
        cell_mode_t mode;
    } cell_cfg_t;

    typedef struct packed {
        logic [3:0] data;
        logic carry_in;
        logic cascade_in;
    } cell_in_t;

    typedef struct packed {
        logic comb;
        logic next_d;
        logic carry_out;
        logic cascade_out;
    } cell_res_t;

endpackage

// ### dv/logic_cell_chk.sv
`timescale 1ns/1ps
`default_nettype none

module logic_cell_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // cell
    input wire cell_pkg::cell_in_t cell_in,
    input wire logic async_clear_n,
    input wire logic async_preset_n,
    input wire logic cluster_control_one,
    input wire logic cluster_control_two,
    input wire logic cell_output,
    input wire logic carry_out,
    input wire logic cascade_out,
    input wire logic reg_q
);
    import cell_pkg::*;
    logic rd;
    assign rd = hsel && htrans[1] && !hwrite && hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // bus and register
    // ----------------------------------------
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_idle; !rd |=> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside data phase");
    property p_inputs;
        rd && haddr[7:0] == 8'h0c |=> hrdata == {22'h0, $past(cluster_control_two), $past(cluster_control_one),
            $past(async_preset_n), $past(async_clear_n), $past(cell_in)};
    endproperty
    a_inputs: assert property (p_inputs) else $error("inputs readback");
    property p_status;
        rd && haddr[7:0] == 8'h08 |=> hrdata == {28'h0, $past(cascade_out), $past(carry_out),
            $past(cascade_out), $past(reg_q)};
    endproperty
    a_status: assert property (p_status) else $error("status readback");
    property p_ctrl_upper; rd && haddr[7:0] == 8'h00 |=> hrdata[31:6] == 26'h0; endproperty
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits not zero");
    property p_upper; rd && (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h10) |=> hrdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("table or count upper bits not zero");
    property p_unmapped; rd && haddr[7:0] > 8'h10 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_clear; !async_clear_n |-> !reg_q; endproperty
    a_clear: assert property (p_clear) else $error("clear did not win");
    property p_preset; async_clear_n && !async_preset_n |-> reg_q; endproperty
    a_preset: assert property (p_preset) else $error("preset ignored");
    property p_outsel; cell_output == cascade_out || cell_output == reg_q; endproperty
    a_outsel: assert property (p_outsel) else $error("output source");
endmodule

bind logic_cell_top logic_cell_chk logic_cell_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hrdata, .hresp, .cell_in, .async_clear_n, .async_preset_n, .cluster_control_one,
    .cluster_control_two, .cell_output, .carry_out, .cascade_out, .reg_q);

`default_nettype wire

// ### dv/neighbour_cell.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// upstream neighbour driving the chains
// ----------------------------------------
module neighbour_cell (
    // its own table results
    input wire logic [1:0] src,
    // chain outputs into the cell under test
    output logic carry_in,
    output logic cascade_in
);
    assign carry_in = src[1];
    assign cascade_in = src[0];
endmodule

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_params.svh"

module testbench;
    import cell_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] data_in = 4'h0;
    logic [1:0] nb_src = 2'h0;
    logic [3:0] ctl = 4'hc;
    logic hreadyout, hresp, cell_output, carry_out, cascade_out, reg_q, nb_carry, nb_casc;
    logic [31:0] hrdata, rd;
    cell_in_t cin_bus;
    int err_total = 0;
    int total_checks = 0;

    always #5 hclk = ~hclk;
    assign cin_bus = {data_in, nb_carry, nb_casc};

    neighbour_cell neighbour_cell_i (.src(nb_src), .carry_in(nb_carry), .cascade_in(nb_casc));
    logic_cell_top logic_cell_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cell_in(cin_bus), .async_clear_n(ctl[3]), .async_preset_n(ctl[2]),
        .cluster_control_one(ctl[1]), .cluster_control_two(ctl[0]), .cell_output(cell_output),
        .carry_out(carry_out), .cascade_out(cascade_out), .reg_q(reg_q));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // {next q, comb, carry out, cascade out}
    function automatic logic [3:0] model(input logic [5:0] c, input logic [15:0] lt, input logic [5:0] ci,
        input logic q);
        logic cm, cy, nq;
        logic [2:0] ix;
        ix = {ci[1], ci[3], ci[2]};
        cy = 1'b0;
        if (c[1] == 1'b0) begin
            cm = c[0] ? lt[ix] : lt[{c[2] ? ci[1] : ci[5], ci[4:2]}];
            if (c[0]) cy = lt[8 + ix];
            if (c[4]) cm = cm & ci[0];
            nq = cm;
        end else begin
            ix = {ci[1], c[0] ? 1'b0 : ci[0], q};
            cm = lt[ix];
            cy = lt[8 + ix];
            nq = ci[3] ? ci[2] : (ci[4] ? cm : q);
            if (c[0] && ci[0]) nq = 1'b0;
        end
        return {nq, cm, cy, cm};
    endfunction

    task automatic ap(input logic [3:0] v, input logic e);
        @(posedge hclk);
        ctl <= v;
        #1;
        chk(reg_q, e);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        chk({cell_output, reg_q}, 2'b00);
        bus(0, `CELL_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(0, `CELL_OFS_LUT, 32'h0);
        chk(rd, 32'h0);
        bus(1, 8'h20, 32'hffffffff);
        bus(0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        bus(1, `CELL_OFS_CTRL, 32'hffffffff);
        bus(0, `CELL_OFS_CTRL, 32'h0);
        chk(rd, 32'h3f);
        bus(1, `CELL_OFS_LUT, 32'hffffffff);
        bus(0, `CELL_OFS_LUT, 32'h0);
        chk(rd, 32'hffff);
        $display("register test done");
    endtask

    task automatic t_sweep(input logic [5:0] c, input logic [15:0] lt);
        logic [3:0] e;
        logic qe;
        bus(1, `CELL_OFS_CTRL, {26'h0, c});
        bus(1, `CELL_OFS_LUT, {16'h0, lt});
        @(posedge hclk);
        ctl <= 4'h4;
        {data_in, nb_src} <= 6'h0;
        @(posedge hclk);
        ctl <= 4'hc;
        e = model(c, lt, 6'h0, 1'b0);
        qe = e[3];
        for (int j = 0; j < 64; j++) begin
            @(posedge hclk);
            {data_in, nb_src} <= j[5:0];
            @(negedge hclk);
            chk(reg_q, qe);
            e = model(c, lt, j[5:0], qe);
            chk(cell_output, c[3] ? qe : e[2]);
            chk(carry_out, e[1]);
            chk(cascade_out, e[0]);
            qe = e[3];
        end
        $display("sweep of ctrl %h done", c);
    endtask

    task automatic t_async;
        bus(1, `CELL_OFS_CTRL, 32'h22);
        bus(1, `CELL_OFS_LUT, 32'h0);
        {data_in, nb_src} <= 6'h0;
        ap(4'h4, 1'b0);
        ap(4'hc, 1'b0);
        bus(1, `CELL_OFS_TOGGLES, 32'h0);
        ap(4'h8, 1'b1);
        ap(4'hc, 1'b1);
        ap(4'hc, 1'b1);
        ap(4'h0, 1'b0);
        ap(4'hc, 1'b0);
        ap(4'hf, 1'b1);
        ap(4'he, 1'b1);
        ap(4'hd, 1'b0);
        ap(4'hc, 1'b0);
        bus(0, `CELL_OFS_TOGGLES, 32'h0);
        chk(rd, 32'h4);
        bus(0, `CELL_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(0, `CELL_OFS_INPUTS, 32'h0);
        chk(rd, 32'hc0);
        $display("async load test done");
    endtask

    task automatic t_reset;
        bus(1'b1, `CELL_OFS_CTRL, 32'h8);
        bus(1'b1, `CELL_OFS_LUT, 32'hffff);
        @(posedge hclk);
        @(negedge hclk);
        chk({cell_output, reg_q}, 2'b11);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk({hreadyout, hresp, cell_output, reg_q}, 4'b1000);
        chk(hrdata, 32'h0);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `CELL_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, `CELL_OFS_LUT, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, `CELL_OFS_TOGGLES, 32'h0);
        chk(rd, 32'h0);
        $display("mid-run reset test done");
    endtask

    initial begin
        #100000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        results;
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_sweep(6'h00, 16'h6996);
        t_sweep(6'h14, 16'h6996);
        t_sweep(6'h08, 16'hfe01);
        t_sweep(6'h11, 16'he896);
        t_sweep(6'h02, 16'h605a);
        t_sweep(6'h0b, 16'h605a);
        t_async;
        t_reset;
        results;
    end
endmodule

`default_nettype wire

// ### hdl/logic_cell_luts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_params.svh"

module logic_cell_luts (
    // configuration
    input wire cell_pkg::cell_cfg_t cfg,
    input wire logic [15:0] lut,
    // cell inputs and register feedback
    input wire cell_pkg::cell_in_t inp,
    input wire logic q,
    // results
    output cell_pkg::cell_res_t res
);
    import cell_pkg::*;

    logic fourth;
    logic [3:0] idx4;
    logic [2:0] idx_arith;
    logic [2:0] idx_count;
    logic [7:0] table_a;
    logic [7:0] table_b;
    logic direction;
    logic sync_clear;
    logic count_bit;
    logic load_sel;
    logic lut_out;

    assign table_a = lut[`TABLE_A_MSB:`TABLE_A_LSB];
    assign table_b = lut[`TABLE_B_MSB:`TABLE_B_LSB];
    // fourth input from data or carry-in
    assign fourth = cfg.fourth_sel ? inp.carry_in : inp.data[`DIN_FOURTH];
    assign idx4 = {fourth, inp.data[2], inp.data[1], inp.data[0]};
    assign idx_arith = {inp.carry_in, inp.data[1], inp.data[0]};
    // cascade-in acts as direction or as clear
    assign direction = (cfg.mode == MODE_UPDOWN) ? inp.cascade_in : 1'b0;
    assign sync_clear = (cfg.mode == MODE_CLEARABLE) & inp.cascade_in;
    assign idx_count = {inp.carry_in, direction, q};
    assign count_bit = inp.data[`DIN_COUNT_EN] ? table_a[idx_count] : q;
    // two-way load selector ahead of the register
    assign load_sel = inp.data[`DIN_LOAD_EN] ? inp.data[`DIN_LOAD_DATA] : count_bit;

    always_comb begin
        lut_out = 1'b0;
        res = '0;
        case (cfg.mode)
            MODE_NORMAL: begin
                lut_out = lut[idx4];
                res.comb = cfg.cascade_en ? (lut_out & inp.cascade_in) : lut_out;
                res.next_d = res.comb;
                res.carry_out = 1'b0;
                res.cascade_out = res.comb;
            end
            MODE_ARITH: begin
                lut_out = table_a[idx_arith];
                res.comb = cfg.cascade_en ? (lut_out & inp.cascade_in) : lut_out;
                res.next_d = res.comb;
                res.carry_out = table_b[idx_arith];
                res.cascade_out = res.comb;
            end
            MODE_UPDOWN: begin
                lut_out = table_a[idx_count];
                res.comb = lut_out;
                res.next_d = load_sel;
                res.carry_out = table_b[idx_count];
                res.cascade_out = lut_out;
            end
            MODE_CLEARABLE: begin
                lut_out = table_a[idx_count];
                res.comb = lut_out;
                res.next_d = load_sel & ~sync_clear;
                res.carry_out = table_b[idx_count];
                res.cascade_out = lut_out;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### hdl/logic_cell_top.sv
// Operation
// - normal mode feeds a 4-input table; a bit picks fourth input or carry-in
// - normal mode may merge table result with cascade-in, driving cascade-out
// - cell output selects the combinational result or the stored register value
// - arithmetic mode: first 3-input table makes sum from carry-in and two inputs
// - arithmetic mode: second table makes carry-out from the same three signals
// - arithmetic mode still allows the cascade chain beside the carry chain
// - up/down counter has count enable, direction and load from inputs and feedback
// - counter modes: one table makes next bit, the other the fast carry
// - up/down counter loads synchronously through a two-way selector before register
// - register loads asynchronously through clear and preset, using no tables
// - clearable counter uses a synchronous clear taken from the cascade-in input
// - clearable counter ANDs the load selector output with the clear term
`timescale 1ns/1ps
`default_nettype none
`include "cell_params.svh"

module logic_cell_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // cluster inputs and chains in
    input wire cell_pkg::cell_in_t cell_in,
    // register controls
    input wire logic async_clear_n,
    input wire logic async_preset_n,
    input wire logic cluster_control_one,
    input wire logic cluster_control_two,
    // cell outputs and chains out
    output logic cell_output,
    output logic carry_out,
    output logic cascade_out,
    output logic reg_q
);
    import cell_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [`CTRL_W-1:0] ctrl;
    logic [`CTRL_W-1:0] next_ctrl;
    logic [`LUT_W-1:0] lut;
    logic [`LUT_W-1:0] next_lut;
    logic [`TOGGLE_W-1:0] toggles;
    logic [`TOGGLE_W-1:0] next_toggles;
    cell_cfg_t cfg;
    cell_res_t res;
    logic q;
    logic q_last;
    logic eff_clear_n;
    logic eff_preset_n;
    logic aload_strobe;
    logic addr_take;
    logic wr_pend;
    logic [`CELL_OFS_W-1:0] wr_addr;
    logic toggle_clear;
    logic [31:0] next_rdata;
    logic [`CELL_OFS_W-1:0] rd_addr;
    logic unused_bits;

    // ----------------------------------------
    // configuration view
    // ----------------------------------------
    assign cfg.mode = cell_mode_t'(ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    assign cfg.fourth_sel = ctrl[`CTRL_FOURTH_BIT];
    assign cfg.out_reg_sel = ctrl[`CTRL_OUTREG_BIT];
    assign cfg.cascade_en = ctrl[`CTRL_CASCADE_BIT];
    assign cfg.aload_en = ctrl[`CTRL_ALOAD_BIT];

    // ----------------------------------------
    // table logic
    // ----------------------------------------
    logic_cell_luts u_luts (
        .cfg(cfg),
        .lut(lut),
        .inp(cell_in),
        .q(q),
        .res(res)
    );

    // ----------------------------------------
    // bus address phase
    // ----------------------------------------
    assign addr_take = hsel & htrans[1] & hready;
    assign rd_addr = haddr[`CELL_OFS_W-1:0];
    assign unused_bits = ^{haddr[31:`CELL_OFS_W], hsize, htrans[0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else if (hready) begin
            wr_pend <= addr_take & hwrite;
            wr_addr <= rd_addr;
        end
    end

    // ----------------------------------------
    // bus response, zero wait states
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // register writes in data phase
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_lut = lut;
        toggle_clear = 1'b0;
        if (wr_pend) begin
            case (wr_addr)
                `CELL_OFS_CTRL: begin
                    next_ctrl = hwdata[`CTRL_W-1:0];
                end
                `CELL_OFS_LUT: begin
                    next_lut = hwdata[`LUT_W-1:0];
                end
                `CELL_OFS_TOGGLES: begin
                    toggle_clear = 1'b1;
                end
                default: begin
                    toggle_clear = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut <= `LUT_RST;
        end else begin
            lut <= next_lut;
        end
    end

    // ----------------------------------------
    // read data, taken at address phase
    // ----------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (rd_addr)
            `CELL_OFS_CTRL: begin
                next_rdata[`CTRL_W-1:0] = next_ctrl;
            end
            `CELL_OFS_LUT: begin
                next_rdata[`LUT_W-1:0] = next_lut;
            end
            `CELL_OFS_STATUS: begin
                next_rdata[`STATUS_W-1:0] = {res.cascade_out, res.carry_out, res.comb, q};
            end
            `CELL_OFS_INPUTS: begin
                next_rdata[`INPUTS_CELL_MSB:0] = cell_in;
                next_rdata[`INPUTS_PIN_MSB:`INPUTS_PIN_LSB] = {cluster_control_two, cluster_control_one,
                    async_preset_n, async_clear_n};
            end
            `CELL_OFS_TOGGLES: begin
                next_rdata[`TOGGLE_W-1:0] = toggles;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take & ~hwrite) begin
            hrdata <= next_rdata;
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // asynchronous load through clear and preset
    // ----------------------------------------
    // control two strobes the load, control one is the data
    assign aload_strobe = cfg.aload_en & cluster_control_two;
    assign eff_clear_n = async_clear_n & ~(aload_strobe & ~cluster_control_one);
    assign eff_preset_n = async_preset_n & ~(aload_strobe & cluster_control_one);

    // ----------------------------------------
    // programmable register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn or negedge eff_clear_n or negedge eff_preset_n) begin
        if (!hresetn) begin
            q <= `Q_RST;
        end else if (!eff_clear_n) begin
            q <= 1'b0;
        end else if (!eff_preset_n) begin
            q <= 1'b1;
        end else begin
            q <= res.next_d;
        end
    end

    // ----------------------------------------
    // register activity counter
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_last <= `Q_RST;
        end else begin
            q_last <= q;
        end
    end

    always_comb begin
        next_toggles = toggles;
        if (toggle_clear) begin
            next_toggles = `TOGGLE_RST;
        end
        if (q != q_last) begin
            next_toggles = toggle_clear ? `TOGGLE_STEP : toggles + `TOGGLE_STEP;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggles <= `TOGGLE_RST;
        end else begin
            toggles <= next_toggles;
        end
    end

    // ----------------------------------------
    // outputs and chains
    // ----------------------------------------
    assign cell_output = cfg.out_reg_sel ? q : res.comb;
    assign carry_out = res.carry_out;
    assign cascade_out = res.cascade_out;
    assign reg_q = q;

endmodule
`default_nettype wire
